// ===== rtl/slpc_ctrl.v
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "slpc_defs.vh"

module slpc_ctrl
(
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // axi4-lite write address
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // core side, same clock domain
    input wire sleep_exec,
    input wire sys_reset_evt,
    // wake sources, asynchronous pins
    input wire ext_level_irq,
    input wire ext_edge_irq,
    input wire pin_change_irq,
    // wake sources from on-clock peripherals
    input wire timer_irq,
    input wire comparator_irq,
    input wire adc_done_irq,
    input wire self_program_ready,
    input wire other_irq,
    // fuse strap
    input wire brownout_level_fuse,
    // clock and power controls
    output reg clk_cpu_en,
    output reg clk_flash_en,
    output reg clk_io_en,
    output reg clk_adc_en,
    output reg osc_en,
    output reg cpu_stall,
    output reg irq_service,
    output reg restart_vector,
    output reg adc_power,
    output reg adc_start,
    output reg adc_extended,
    output reg comparator_power,
    output reg vref_power,
    output reg brownout_power,
    output reg wdt_run,
    output reg input_buf_en,
    output reg wake_buf_en
);

    // state codes
    localparam ST_RUN = 2'd0;
    localparam ST_SLEEP = 2'd1;
    localparam ST_STALL = 2'd2;

    reg [7:0] pcr_r;
    reg [7:0] cfg_r;
    reg [1:0] st_r;
    reg [1:0] st_nxt;
    reg [1:0] mode_r;
    reg [2:0] cnt_r;
    reg adc_was_r;
    reg ext_pend_r;
    reg [2:0] sync1_r;
    reg [2:0] sync2_r;
    reg aw_hold_r;
    reg w_hold_r;
    reg [3:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    wire lvl_s;
    wire edge_s;
    wire pc_s;
    wire [1:0] sm;
    wire se;
    wire adc_en;
    wire cmp_off;
    wire cmp_bg;
    wire wdt_en;
    wire go_sleep;
    wire wake;
    wire cmp_on_nxt;
    wire [1:0] mode_eff;
    wire wr_fire;

    assign sm = {pcr_r[`SLPC_PCR_SM_HI], pcr_r[`SLPC_PCR_SM_LO]};
    assign se = pcr_r[`SLPC_PCR_SE];
    assign adc_en = cfg_r[`SLPC_CFG_ADC_EN];
    assign cmp_off = cfg_r[`SLPC_CFG_CMP_OFF];
    assign cmp_bg = cfg_r[`SLPC_CFG_CMP_BG];
    assign wdt_en = cfg_r[`SLPC_CFG_WDT_EN];
    assign lvl_s = sync2_r[0];
    assign edge_s = sync2_r[1];
    assign pc_s = sync2_r[2];

    // pin synchronisers, first stage read only by second
    // pins are asynchronous to sys_clk, two stages keep metastability out of the filter
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
        end
        else
        begin
            sync1_r <= {pin_change_irq, ext_edge_irq, ext_level_irq};
            sync2_r <= sync1_r;
        end
    end

    // sleep only with enable bit set and a legal mode
    assign go_sleep = sleep_exec && se && (sm != `SLPC_MODE_RSVD);

    // per-mode wake filter; edge interrupt only wakes idle
    assign wake = (mode_r == `SLPC_MODE_IDLE) ?
                      (lvl_s | edge_s | pc_s | timer_irq | comparator_irq | adc_done_irq |
                       self_program_ready | other_irq) :
                  (mode_r == `SLPC_MODE_ADCNR) ?
                      (lvl_s | pc_s | adc_done_irq | self_program_ready) :
                      (lvl_s | pc_s);

    // gates follow the mode being entered, mode_r only catches up one edge later
    assign mode_eff = (st_r == ST_RUN) ? sm : mode_r;

    // comparator forced off in power-down
    assign cmp_on_nxt = !cmp_off && !(st_nxt == ST_SLEEP && mode_eff == `SLPC_MODE_PDOWN);

    // sleep sequencer
    always @*
    begin
        st_nxt = st_r;
        case (st_r)
            ST_RUN:
                if (go_sleep)
                    st_nxt = ST_SLEEP;
            ST_SLEEP:
                if (wake)
                    st_nxt = ST_STALL;
            ST_STALL:
                if (cnt_r == 3'h0)
                    st_nxt = ST_RUN;
            default:
                st_nxt = ST_RUN;
        endcase
        // a reset event overrides any step, so gates reopen on the same edge
        if (sys_reset_evt)
            st_nxt = ST_RUN;
    end

    // state, mode latch and stall counter; resets end in run via rst_n or event
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= ST_RUN;
            mode_r <= `SLPC_MODE_IDLE;
            cnt_r <= 3'h0;
            irq_service <= 1'b0;
            restart_vector <= 1'b0;
        end
        else if (sys_reset_evt)
        begin
            // watchdog, brown-out or pin reset wakes to the reset vector
            st_r <= ST_RUN;
            cnt_r <= 3'h0;
            irq_service <= 1'b0;
            restart_vector <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
            restart_vector <= 1'b0;
            if (st_r == ST_RUN && go_sleep)
                mode_r <= sm;
            if (st_r == ST_SLEEP && wake)
                cnt_r <= `SLPC_STARTUP + `SLPC_WAKE_STALL - 3'h1;
            else if (cnt_r != 3'h0)
                cnt_r <= cnt_r - 3'h1;
            irq_service <= (st_r == ST_STALL) && (cnt_r == 3'h0);
        end
    end

    // clock gates and power switches; datapath state is never cleared here
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clk_cpu_en <= 1'b1;
            clk_flash_en <= 1'b1;
            clk_io_en <= 1'b1;
            clk_adc_en <= 1'b1;
            osc_en <= 1'b1;
            cpu_stall <= 1'b0;
            adc_power <= 1'b0;
            adc_start <= 1'b0;
            adc_extended <= 1'b0;
            comparator_power <= 1'b0;
            vref_power <= 1'b0;
            brownout_power <= 1'b0;
            wdt_run <= 1'b0;
            input_buf_en <= 1'b1;
            wake_buf_en <= 1'b1;
            adc_was_r <= 1'b0;
        end
        else
        begin
            // cpu stays frozen through sleep and stall, so registers and sram hold
            cpu_stall <= (st_nxt != ST_RUN);
            clk_cpu_en <= (st_nxt != ST_SLEEP);
            clk_flash_en <= (st_nxt != ST_SLEEP);
            clk_io_en <= !(st_nxt == ST_SLEEP && mode_eff != `SLPC_MODE_IDLE);
            clk_adc_en <= !(st_nxt == ST_SLEEP && mode_eff == `SLPC_MODE_PDOWN);
            osc_en <= !(st_nxt == ST_SLEEP && mode_eff == `SLPC_MODE_PDOWN);
            adc_power <= adc_en;
            adc_start <= adc_en && st_r == ST_RUN && st_nxt == ST_SLEEP && sm != `SLPC_MODE_PDOWN;
            adc_was_r <= adc_en;
            // re-enable flags an extended conversion until a start consumes it
            if (adc_en && !adc_was_r)
                adc_extended <= 1'b1;
            else if (adc_start)
                adc_extended <= 1'b0;
            comparator_power <= cmp_on_nxt;
            // bandgap follows its three users, sleep does not matter
            vref_power <= brownout_level_fuse | (cmp_bg & !cmp_off) | adc_en;
            brownout_power <= brownout_level_fuse;
            wdt_run <= wdt_en;
            // input buffers switch off only in power-down, where io and adc clocks both stop
            input_buf_en <= !(st_nxt == ST_SLEEP && mode_eff == `SLPC_MODE_PDOWN);
            // wake pins must be sensed in every mode, so their buffers never switch off
            wake_buf_en <= 1'b1;
        end
    end

    // axi write path: address and data taken in either order
    assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;

    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SLPC_RESP_OKAY;
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
            pcr_r <= `SLPC_PCR_RST;
            cfg_r <= `SLPC_CFG_RST;
        end
        else
        begin
            s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `SLPC_RESP_OKAY;
                case (aw_addr_r)
                    `SLPC_ADDR_PCR:
                        if (w_strb_r[0])
                            pcr_r <= w_data_r[7:0] & `SLPC_PCR_MASK;
                    `SLPC_ADDR_CFG:
                        if (w_strb_r[0])
                            cfg_r <= w_data_r[7:0] & `SLPC_CFG_MASK;
                    // status is read-only, a write there is dropped without error
                    `SLPC_ADDR_STAT:
                        s_axi_bresp <= `SLPC_RESP_OKAY;
                    default:
                        s_axi_bresp <= `SLPC_RESP_SLVERR;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // axi read path, one cycle after the address is taken
    // reads have no side effects, so a repeated read is harmless
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `SLPC_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `SLPC_RESP_OKAY;
                case (s_axi_araddr)
                    `SLPC_ADDR_PCR:
                        s_axi_rdata <= {24'h0, pcr_r};
                    `SLPC_ADDR_CFG:
                        s_axi_rdata <= {24'h0, cfg_r};
                    `SLPC_ADDR_STAT:
                        s_axi_rdata <= {24'h0, 1'b0, adc_extended, comparator_power, vref_power,
                                        mode_r, st_r};
                    default:
                    begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= `SLPC_RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule // slpc_ctrl
`default_nettype wire

// ===== rtl/slpc_defs.vh
`ifndef SLPC_DEFS_VH
`define SLPC_DEFS_VH

// register byte addresses (chosen)
`define SLPC_ADDR_PCR 4'h0
`define SLPC_ADDR_CFG 4'h4
`define SLPC_ADDR_STAT 4'h8

// power control register fields
`define SLPC_PCR_SE 5
`define SLPC_PCR_SM_HI 4
`define SLPC_PCR_SM_LO 3
`define SLPC_PCR_MASK 8'h7b
`define SLPC_PCR_RST 8'h00

// config register fields
`define SLPC_CFG_ADC_EN 0
`define SLPC_CFG_CMP_OFF 1
`define SLPC_CFG_CMP_BG 2
`define SLPC_CFG_WDT_EN 3
`define SLPC_CFG_MASK 8'h0f
`define SLPC_CFG_RST 8'h00

// sleep mode encodings
`define SLPC_MODE_IDLE 2'b00
`define SLPC_MODE_ADCNR 2'b01
`define SLPC_MODE_PDOWN 2'b10
`define SLPC_MODE_RSVD 2'b11

// wake stall beyond start-up, in cycles
`define SLPC_WAKE_STALL 3'h4
`define SLPC_STARTUP 3'h2

// axi response codes
`define SLPC_RESP_OKAY 2'b00
`define SLPC_RESP_SLVERR 2'b10

`endif

// ===== sim/slpc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// core stand-in: issues the sleep instruction and drives the level wake line
module slpc_core_model
(
    // clock
    input wire logic sys_clk,
    // bench requests
    input wire logic go_sleep,
    input wire logic wake_req,
    // device status
    input wire logic cpu_stall,
    // towards the device
    output logic sleep_exec,
    output logic ext_level_irq
);
    initial sleep_exec = 1'b0;
    initial ext_level_irq = 1'b0;
    // one-cycle sleep instruction
    always @(posedge sys_clk)
        sleep_exec <= go_sleep;
    // level held until awake, a shorter level could be missed by the synchroniser
    always @(posedge sys_clk)
        ext_level_irq <= wake_req | (ext_level_irq & cpu_stall);
endmodule // slpc_core_model
`default_nettype wire

// ===== sim/slpc_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module slpc_ctrl_sva
(
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // core and strap
    input wire sleep_exec,
    input wire brownout_level_fuse,
    // clock gates and status
    input wire clk_cpu_en,
    input wire clk_flash_en,
    input wire clk_io_en,
    input wire clk_adc_en,
    input wire osc_en,
    input wire cpu_stall,
    input wire irq_service,
    // power controls
    input wire adc_power,
    input wire adc_start,
    input wire comparator_power,
    input wire vref_power,
    input wire brownout_power,
    input wire wdt_run,
    input wire input_buf_en
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // entry into sleep shows as stall rising
    sequence enter_s;
        $rose(cpu_stall);
    endsequence
    sequence enter_pd_s;
        enter_s ##0 !osc_en;
    endsequence
    a_entry_needs_exec: assert property (enter_s |-> $past(sleep_exec))
        else $error("stall rose without a sleep instruction");
    a_core_clk_off: assert property (enter_s |-> !clk_cpu_en && !clk_flash_en)
        else $error("core clocks still running in sleep");
    a_nr_adc_on: assert property (enter_s ##0 osc_en && !clk_io_en |-> clk_adc_en)
        else $error("adc clock stopped in noise reduction");
    a_pdown_all_off: assert property (enter_pd_s |->
        !clk_io_en && !clk_adc_en && !comparator_power && !input_buf_en)
        else $error("power-down left something on");
    a_service_after_stall: assert property (irq_service |-> $past(cpu_stall) && $past(cpu_stall, 4))
        else $error("service without four stalled cycles");
    a_service_one_pulse: assert property (irq_service |=> !irq_service)
        else $error("service pulse too long");
    a_bod_fuse: assert property ($past(rst_n) |-> brownout_power == $past(brownout_level_fuse))
        else $error("brown-out power does not follow strap");
    a_vref_needed: assert property (adc_power || brownout_power |-> vref_power)
        else $error("reference off while needed");
    a_adc_kick: assert property (adc_start |-> adc_power ##1 !adc_start)
        else $error("bad conversion start pulse");
    a_wdt_kept: assert property (enter_s |-> wdt_run == $past(wdt_run))
        else $error("watchdog changed on sleep entry");
endmodule // slpc_ctrl_sva
bind slpc_ctrl slpc_ctrl_sva slpc_ctrl_sva_inst (.*);
`default_nettype wire

// ===== sim/slpc_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module slpc_ctrl_tb_top;
    logic sys_clk = 1'b0, rst_n = 1'b0, go_sleep = 1'b0, wake_req = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, rdat;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic sys_reset_evt = 1'b0, brownout_level_fuse = 1'b0, hit, ext_exp = 1'b0;
    logic [6:0] src = 7'h0;
    logic [1:0] resp;
    int seed = 51, mismatches = 0, n_compared = 0, n_start = 0, n_restart = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en, osc_en, cpu_stall, irq_service;
    wire restart_vector, adc_power, adc_start, adc_extended, comparator_power, vref_power;
    wire brownout_power, wdt_run, input_buf_en, wake_buf_en, sleep_exec, ext_level_irq;
    // src: timer, comparator, adc done, self-program, other, edge, pin change
    slpc_ctrl slpc_ctrl_inst (.*, .ext_edge_irq(src[5]), .pin_change_irq(src[6]), .timer_irq(src[0]),
        .comparator_irq(src[1]), .adc_done_irq(src[2]), .self_program_ready(src[3]), .other_irq(src[4]));
    slpc_core_model slpc_core_model_inst (.*);
    // 250 MHz
    initial forever #2 sys_clk = ~sys_clk;
    // pulse counters
    always @(posedge sys_clk)
    begin
        n_start <= n_start + int'(adc_start);
        n_restart <= n_restart + int'(restart_vector);
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // master holds each valid until its own ready, bready and rready stay high
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
    endtask
    task automatic rd(input logic [3:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        resp = s_axi_rresp;
        rdat = s_axi_rdata;
    endtask
    // expected {cpu, flash, io, adc, osc} while asleep
    function automatic logic [4:0] ck(input logic [1:0] m);
        case (m)
            2'b00: ck = 5'h07;
            2'b01: ck = 5'h03;
            2'b10: ck = 5'h00;
            default: ck = 5'h1f;
        endcase
    endfunction
    // source 7 is a reset event
    function automatic logic wk(input logic [1:0] m, input int s);
        wk = (m == 2'b00) || (s >= 6) || (m == 2'b01 && (s == 2 || s == 3));
    endfunction
    // bounded wait for the stall to end
    task automatic nap_wait;
        int n;
        n = 0;
        while (cpu_stall === 1'b1 && n < 40)
        begin
            @(posedge sys_clk);
            sys_reset_evt <= 1'b0;
            hit = hit | irq_service;
            n++;
        end
        repeat (2)
        begin
            @(posedge sys_clk);
            hit = hit | irq_service;
        end
    endtask
    task automatic nap(input logic [1:0] m, input int s);
        hit = 1'b0;
        wr(4'h0, {26'h0, 1'b1, m, 3'h0});
        go_sleep <= 1'b1;
        @(posedge sys_clk);
        go_sleep <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk(cpu_stall, m != 2'b11);
        chk({clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en, osc_en}, ck(m));
        chk({input_buf_en, wake_buf_en}, {m != 2'b10, 1'b1});
        if (m != 2'b11)
        begin
            // status asleep: comparator off only in power-down, strap keeps vref on
            rd(4'h8);
            chk(rdat, {26'h0, m != 2'b10, 1'b1, m, 2'b01});
        end
        if (s == 7) sys_reset_evt <= 1'b1;
        else src[s] <= 1'b1;
        nap_wait;
        src <= 7'h0;
        chk(cpu_stall, m != 2'b11 && !wk(m, s));
        chk(hit, m != 2'b11 && wk(m, s) && s != 7);
        wake_req <= 1'b1;
        @(posedge sys_clk);
        wake_req <= 1'b0;
        nap_wait;
        chk(cpu_stall, 1'b0);
        wr(4'h0, 32'h0);
    endtask
    // watchdog, far beyond the 1300 or so cycles the run needs
    initial
    begin
        #100000;
        mismatches++;
        close_out;
    end
    initial
    begin
        logic [31:0] d;
        logic f;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rd(4'h0);
        chk(rdat, 32'h0);
        rd(4'h4);
        chk(rdat, 32'h0);
        rd(4'hc);
        chk({resp, rdat}, {2'b10, 32'h0});
        wr(4'hc, 32'hff);
        chk(resp, 2'b10);
        repeat (8)
        begin
            d = $random(seed);
            wr(4'h0, d);
            rd(4'h0);
            chk(rdat, d & 32'h7b);
            wr(4'h4, d);
            ext_exp = ext_exp | d[0];
            rd(4'h4);
            chk(rdat, d & 32'hf);
        end
        wr(4'h0, 32'h0);
        for (int c = 0; c < 16; c++)
        begin
            f = c[3] ^ c[1];
            brownout_level_fuse <= f;
            wr(4'h4, c);
            repeat (2) @(posedge sys_clk);
            chk({vref_power, brownout_power, comparator_power, adc_power, wdt_run, adc_extended},
                {c[0] | (c[2] & !c[1]) | f, f, !c[1], c[0], c[3], ext_exp | (c >= 1)});
        end
        brownout_level_fuse <= 1'b1;
        wr(4'h4, 32'hd);
        for (int m = 0; m < 3; m++)
            for (int s = 0; s < 8; s++)
                nap(m[1:0], s);
        nap(2'b11, 0);
        chk(n_start, 16);
        chk(n_restart, 3);
        chk(adc_extended, 1'b0);
        rd(4'h4);
        chk(rdat, 32'hd);
        close_out;
    end
endmodule // slpc_ctrl_tb_top
`default_nettype wire
